// [gpib_consts.svh]
`ifndef GPIB_CONSTS_SVH
`define GPIB_CONSTS_SVH
`define LISTEN_BASE 8'h20
`define TALK_BASE 8'h40
`define ADDR_MASK 8'h60
`define SECONDARY_BASE 8'h60
`define UNLISTEN_CODE 8'h3F
`define UNTALK_CODE 8'h5F
`define PRIMARY_MAX 5'h1E
`define PRIMARY_RESET 5'h00
`define SETTLE_NS 100
`define CLK_PERIOD_NS 5
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [gpib_pkg.sv]
package gpib_pkg;
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_WAIT = 2'b01,
    SRC_VALID = 2'b11,
    SRC_DONE = 2'b10
  } src_state_e;
  typedef enum logic [1:0] {
    ACC_READY = 2'b00,
    ACC_TAKE = 2'b01,
    ACC_HOLD = 2'b11
  } acc_state_e;
endpackage

// [gpib_out_reg.sv]
`timescale 1ns/1ps
// holds one outgoing byte with its end flag until the source consumes it
module gpib_out_reg (
  input wire logic mclk, // clock
  input wire logic rst, // async reset
  input wire logic ce, // clock enable
  input wire logic wr, // load strobe
  input wire logic [7:0] wdata, // byte to hold
  input wire logic wend, // end flag
  input wire logic rd, // consume strobe
  output logic full, // byte held
  output logic [7:0] rdata, // held byte
  output logic rend // held end flag
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      full <= 1'b0;
      rdata <= 8'h00;
      rend <= 1'b0;
    end else if (ce) begin
      if (wr && !full) begin
        full <= 1'b1;
        rdata <= wdata;
        rend <= wend;
      end else if (rd) begin
        full <= 1'b0;
      end
    end
  end
endmodule

// [gpib_talker_listener_port.sv]
`timescale 1ns/1ps
`include "gpib_consts.svh"
// Summary of operation
// - listen address is primary address ORed with 20h; entering listener state.
// - talk address is primary address ORed with 40h; entering talker state.
// - primary address setting accepts only 0 to 30, used for both matches.
// - command bytes 60h..7Fh are secondary, never matched as own address.
// - every bus line is low true; high means false or released.
// - eight data lines carry one byte per handshake; driven only as source.
// - with attention low, each handshaked byte is a bus command.
// - with attention high, listener bytes pass out as device data.
// - single-line commands come only from management lines, no handshake.
// - source waits for ready high and accepted low before data valid.
// - acceptor lines settle within 100 ns after attention asserts.
// - source drives data valid low and keeps byte stable meanwhile.
// - acceptor pulls ready low, releases accepted after taking the byte.
// - handshake fully interlocked, pace follows slowest acceptor.
// - only one talker; device drives data only while addressed to talk.
// - talker sends output string one byte per handshake.
// - device asserts service request low whenever it needs attention.
// - remote enable low puts device into remote operation.
// - interface clear clears the device's bus interface state.
// - end line marks last byte both as talker and as listener.
// - interface clear returns device to talker idle and listener idle.
// - unlisten 3Fh gives listener idle; untalk 5Fh gives talker idle.
module gpib_talker_listener_port
  import gpib_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst, // async reset
  input wire logic ce, // clock enable
  input wire logic [4:0] primary_addr, // configured address
  input wire logic [7:0] dio_n_in, // data lines in
  output logic [7:0] dio_n_out, // data lines out
  output logic [7:0] dio_n_oe_n, // data output enable
  input wire logic atn_n, // attention
  input wire logic ifc_n, // interface clear
  input wire logic ren_n, // remote enable
  input wire logic eoi_n_in, // end line in
  output logic eoi_n_out, // end line out
  output logic eoi_n_oe_n, // end output enable
  output logic srq_n_out, // service request out
  output logic srq_n_oe_n, // service request enable
  input wire logic dav_n_in, // data valid in
  output logic dav_n_out, // data valid out
  output logic dav_n_oe_n, // data valid enable
  input wire logic nrfd_n_in, // not ready in
  output logic nrfd_n_out, // not ready out
  output logic nrfd_n_oe_n, // not ready enable
  input wire logic ndac_n_in, // not accepted in
  output logic ndac_n_out, // not accepted out
  output logic ndac_n_oe_n, // not accepted enable
  input wire logic tx_valid, // byte to send
  input wire logic [7:0] tx_data, // byte value
  input wire logic tx_last, // final byte
  output logic tx_ready, // can take byte
  input wire logic rx_ready, // user can take byte
  output logic rx_valid, // received data pulse
  output logic [7:0] rx_data, // received byte
  output logic rx_last, // received with end
  output logic cmd_valid, // received command pulse
  output logic [7:0] cmd_data, // command byte
  input wire logic service_req, // user wants attention
  output logic talker, // addressed to talk
  output logic listener, // addressed to listen
  output logic remote // remote operation
);
  src_state_e src_state;
  src_state_e next_src_state;
  acc_state_e acc_state;
  acc_state_e next_acc_state;
  logic [7:0] hold_data;
  logic hold_end;
  logic hold_full;
  logic [4:0] addr;
  logic [5:0] settle;
  logic atn_q;

  // bus lines are low true: decode to positive logic
  wire atn = !atn_n;
  wire ifc = !ifc_n;
  wire dav = !dav_n_in;
  wire nrfd = !nrfd_n_in;
  wire ndac = !ndac_n_in;
  wire [7:0] bus_byte = ~dio_n_in;
  wire [7:0] cmd7 = {1'b0, bus_byte[6:0]};
  wire addr_ok = (primary_addr <= `PRIMARY_MAX);
  wire [7:0] listen_addr = `LISTEN_BASE | {3'h0, addr};
  wire [7:0] talk_addr = `TALK_BASE | {3'h0, addr};
  wire is_secondary = (cmd7 & `ADDR_MASK) == `SECONDARY_BASE;

  function automatic logic match(input logic [7:0] b, input logic [7:0] a, input logic sec);
    match = !sec && (b == a);
  endfunction

  wire acc_take = (acc_state == ACC_READY) && dav && (atn || listener);
  wire take_cmd = acc_take && atn;
  wire take_data = acc_take && !atn;
  wire hit_listen = take_cmd && match(cmd7, listen_addr, is_secondary);
  wire hit_talk = take_cmd && match(cmd7, talk_addr, is_secondary);
  wire hit_unl = take_cmd && (cmd7 == `UNLISTEN_CODE);
  wire hit_unt = take_cmd && (cmd7 == `UNTALK_CODE) && !hit_talk;
  wire other_talk = take_cmd && ((cmd7 & 8'hE0) == `TALK_BASE) && !hit_talk && !hit_unt;
  wire next_talker = ifc ? 1'b0 : hit_talk ? 1'b1 : (hit_unt || other_talk) ? 1'b0 : talker;
  wire next_listener = ifc ? 1'b0 : hit_listen ? 1'b1 : hit_unl ? 1'b0 : listener;
  wire settled = (settle == 6'h00);
  wire src_go = talker && !atn && settled;

  // acceptor: ready, take byte, hold ndac released until source drops valid
  always_comb begin
    next_acc_state = acc_state;
    unique case (acc_state)
      ACC_READY: if (acc_take && (atn || rx_ready)) next_acc_state = ACC_TAKE;
      ACC_TAKE: next_acc_state = ACC_HOLD;
      ACC_HOLD: if (!dav) next_acc_state = ACC_READY;
      default: next_acc_state = ACC_READY;
    endcase
  end

  // source: wait for ready, assert valid, wait accepted, release
  always_comb begin
    next_src_state = src_state;
    unique case (src_state)
      SRC_IDLE: if (src_go && hold_full) next_src_state = SRC_WAIT;
      SRC_WAIT: if (!src_go) next_src_state = SRC_IDLE;
        else if (!nrfd && ndac) next_src_state = SRC_VALID;
      SRC_VALID: if (!ndac) next_src_state = SRC_DONE;
      SRC_DONE: next_src_state = SRC_IDLE;
    endcase
  end

  wire consume = (src_state == SRC_VALID) && !ndac;

  gpib_out_reg u_out (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wr(tx_valid && tx_ready),
    .wdata(tx_data),
    .wend(tx_last),
    .rd(consume),
    .full(hold_full),
    .rdata(hold_data),
    .rend(hold_end)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr <= `PRIMARY_RESET;
      atn_q <= 1'b0;
      settle <= 6'h00;
    end else if (ce) begin
      if (addr_ok) addr <= primary_addr;
      atn_q <= atn;
      if (atn && !atn_q) settle <= 6'(`SETTLE_CYCLES);
      else if (!settled) settle <= settle - 6'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_state <= ACC_READY;
      src_state <= SRC_IDLE;
      talker <= 1'b0;
      listener <= 1'b0;
    end else if (ce) begin
      acc_state <= ifc ? ACC_READY : next_acc_state;
      src_state <= (ifc || !src_go) ? SRC_IDLE : next_src_state;
      talker <= next_talker;
      listener <= next_listener;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_last <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_data <= 8'h00;
    end else if (ce) begin
      rx_valid <= take_data && rx_ready && !ifc;
      cmd_valid <= take_cmd && !ifc;
      if (acc_take) begin
        rx_data <= bus_byte;
        cmd_data <= cmd7;
        rx_last <= !eoi_n_in && !atn;
      end
    end
  end

  // pin drivers: enables low while driving
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dio_n_out <= 8'hFF;
      dio_n_oe_n <= 8'hFF;
      eoi_n_out <= 1'b1;
      eoi_n_oe_n <= 1'b1;
      dav_n_out <= 1'b1;
      dav_n_oe_n <= 1'b1;
      nrfd_n_out <= 1'b1;
      nrfd_n_oe_n <= 1'b1;
      ndac_n_out <= 1'b1;
      ndac_n_oe_n <= 1'b1;
      srq_n_out <= 1'b1;
      srq_n_oe_n <= 1'b1;
      remote <= 1'b0;
      tx_ready <= 1'b0;
    end else if (ce) begin
      dio_n_out <= ~hold_data;
      dio_n_oe_n <= {8{!(next_talker && !ifc && src_go && hold_full)}};
      eoi_n_out <= !hold_end;
      eoi_n_oe_n <= !(next_src_state == SRC_VALID && hold_end && !ifc);
      dav_n_out <= 1'b0;
      dav_n_oe_n <= !(next_src_state == SRC_VALID && src_go && !ifc);
      nrfd_n_out <= 1'b0;
      nrfd_n_oe_n <= !((atn || next_listener) && !ifc
        && (next_acc_state != ACC_READY || (!atn && !rx_ready)));
      ndac_n_out <= 1'b0;
      ndac_n_oe_n <= !((atn || next_listener) && !ifc && next_acc_state != ACC_HOLD);
      srq_n_out <= 1'b0;
      srq_n_oe_n <= !service_req;
      remote <= !ren_n;
      // drop ready on the load edge so a held offer is not lost
      tx_ready <= !hold_full && !(tx_valid && tx_ready);
    end
  end

  property p_ifc_idle;
    @(posedge mclk) disable iff (rst) ce && ifc |=> !talker && !listener;
  endproperty
  a_ifc_idle: assert property (p_ifc_idle) else $error("ifc left addressed");
  property p_talk_hit;
    @(posedge mclk) disable iff (rst) ce && hit_talk && !ifc |=> talker;
  endproperty
  a_talk_hit: assert property (p_talk_hit) else $error("talk address missed");
  property p_listen_hit;
    @(posedge mclk) disable iff (rst) ce && hit_listen && !ifc |=> listener;
  endproperty
  a_listen_hit: assert property (p_listen_hit) else $error("listen address missed");
  property p_unl;
    @(posedge mclk) disable iff (rst) ce && hit_unl && !hit_listen |=> !listener;
  endproperty
  a_unl: assert property (p_unl) else $error("unlisten ignored");
  property p_drive_talk;
    @(posedge mclk) disable iff (rst) dio_n_oe_n != 8'hFF |-> talker;
  endproperty
  a_drive_talk: assert property (p_drive_talk) else $error("data driven not talking");
  property p_dav_ready;
    @(posedge mclk) disable iff (rst) $fell(dav_n_oe_n) |-> $past(!nrfd && ndac);
  endproperty
  a_dav_ready: assert property (p_dav_ready) else $error("valid before ready");
  property p_stable;
    @(posedge mclk) disable iff (rst) !dav_n_oe_n && $past(!dav_n_oe_n) |-> $stable(dio_n_out);
  endproperty
  a_stable: assert property (p_stable) else $error("data moved under valid");
  property p_remote;
    @(posedge mclk) disable iff (rst) ce && !ren_n |=> remote;
  endproperty
  a_remote: assert property (p_remote) else $error("remote not entered");
  property p_srq;
    @(posedge mclk) disable iff (rst) ce && service_req |=> !srq_n_oe_n;
  endproperty
  a_srq: assert property (p_srq) else $error("service request not driven");
  property p_no_sec;
    @(posedge mclk) disable iff (rst) ce && take_cmd && is_secondary && !ifc && !talker |=> !talker;
  endproperty
  a_no_sec: assert property (p_no_sec) else $error("secondary taken as address");
  c_talk: cover property (@(posedge mclk) hit_talk);
  c_listen: cover property (@(posedge mclk) hit_listen);
  c_send: cover property (@(posedge mclk) consume);
  c_rx: cover property (@(posedge mclk) rx_valid && rx_last);
endmodule

// [gpib_ctrl_model.sv]
`timescale 1ns/1ps
module gpib_ctrl_model (
  input wire logic mclk, // clock
  input wire logic [7:0] dio_n, // resolved data lines
  input wire logic dav_n, // resolved data valid
  input wire logic ndac_n, // resolved not accepted
  input wire logic nrfd_n, // resolved not ready
  input wire logic eoi_n, // resolved end line
  output logic atn_n, // attention
  output logic ifc_n, // interface clear
  output logic ren_n, // remote enable
  output logic [7:0] dio_m, // own data drive
  output logic eoi_m, // own end drive
  output logic dav_m, // own valid drive
  output logic nrfd_m, // own not ready drive
  output logic ndac_m // own not accepted drive
);
  initial begin
    {atn_n, ifc_n, ren_n, eoi_m, dav_m, nrfd_m, ndac_m} = 7'h7F;
    dio_m = 8'hFF;
  end
  // single-line commands, no handshake
  task automatic uni(input logic ifc, input logic ren);
    @(negedge mclk);
    ifc_n = ~ifc;
    ren_n = ~ren;
  endtask
  task automatic send(input logic [7:0] b, input logic cmd, input logic last, output logic ok);
    int n;
    @(negedge mclk);
    {nrfd_m, ndac_m} = 2'h3;
    atn_n = ~cmd;
    repeat (21) @(negedge mclk);
    dio_m = ~b;
    eoi_m = ~last;
    n = 0;
    while (!(nrfd_n && !ndac_n) && n < 300) begin
      @(negedge mclk);
      n++;
    end
    dav_m = 1'b0;
    while (!ndac_n && n < 600) begin
      @(negedge mclk);
      n++;
    end
    {dav_m, eoi_m, atn_n} = 3'h7;
    dio_m = 8'hFF;
    ok = (n < 300);
  endtask
  task automatic recv(input int slow, output logic [7:0] b, output logic last, output logic ok);
    int n;
    @(negedge mclk);
    ndac_m = 1'b0;
    nrfd_m = 1'b1;
    n = 0;
    while (dav_n && n < 600) begin
      @(negedge mclk);
      n++;
    end
    nrfd_m = 1'b0;
    repeat (slow) @(negedge mclk);
    b = ~dio_n;
    last = ~eoi_n;
    ndac_m = 1'b1;
    while (!dav_n && n < 900) begin
      @(negedge mclk);
      n++;
    end
    ndac_m = 1'b0;
    ok = (n < 600);
  endtask
endmodule

// [tb_gpib_talker_listener_port.sv]
`timescale 1ns/1ps
module tb_gpib_talker_listener_port;
  logic mclk, rst, ce, atn_n, ifc_n, ren_n, eoi_n_out, eoi_n_oe_n, srq_n_out, srq_n_oe_n;
  logic dav_n_out, dav_n_oe_n, nrfd_n_out, nrfd_n_oe_n, ndac_n_out, ndac_n_oe_n;
  logic tx_valid, tx_last, tx_ready, rx_ready, rx_valid, rx_last, cmd_valid;
  logic service_req, talker, listener, remote, eoi_m, dav_m, nrfd_m, ndac_m, last_end;
  logic [4:0] primary_addr;
  logic [7:0] dio_n_out, dio_n_oe_n, tx_data, rx_data, cmd_data, dio_m, last_cmd, last_rx;
  wire [7:0] dio = dio_m & (dio_n_out | dio_n_oe_n);
  wire eoi = eoi_m & (eoi_n_out | eoi_n_oe_n);
  wire dav = dav_m & (dav_n_out | dav_n_oe_n);
  wire nrfd = nrfd_m & (nrfd_n_out | nrfd_n_oe_n);
  wire ndac = ndac_m & (ndac_n_out | ndac_n_oe_n);
  wire srq = srq_n_out | srq_n_oe_n;
  int err_total = 0;
  int compares = 0;
  gpib_talker_listener_port u_gpib_talker_listener_port (.mclk(mclk), .rst(rst), .ce(ce),
    .primary_addr(primary_addr), .dio_n_in(dio), .dio_n_out(dio_n_out),
    .dio_n_oe_n(dio_n_oe_n), .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n), .eoi_n_in(eoi),
    .eoi_n_out(eoi_n_out), .eoi_n_oe_n(eoi_n_oe_n), .srq_n_out(srq_n_out),
    .srq_n_oe_n(srq_n_oe_n), .dav_n_in(dav), .dav_n_out(dav_n_out), .dav_n_oe_n(dav_n_oe_n),
    .nrfd_n_in(nrfd), .nrfd_n_out(nrfd_n_out), .nrfd_n_oe_n(nrfd_n_oe_n), .ndac_n_in(ndac),
    .ndac_n_out(ndac_n_out), .ndac_n_oe_n(ndac_n_oe_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .service_req(service_req), .talker(talker), .listener(listener),
    .remote(remote));
  gpib_ctrl_model u_gpib_ctrl_model (.mclk(mclk), .dio_n(dio), .dav_n(dav), .ndac_n(ndac),
    .nrfd_n(nrfd), .eoi_n(eoi), .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n), .dio_m(dio_m),
    .eoi_m(eoi_m), .dav_m(dav_m), .nrfd_m(nrfd_m), .ndac_m(ndac_m));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (cmd_valid) last_cmd <= cmd_data;
    if (rx_valid) last_rx <= rx_data;
    if (rx_valid) last_end <= rx_last;
  end
  task automatic end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic hs(input logic ok);
    chk1("handshake", 1'b1, ok);
    if (ok !== 1'b1) end_of_test;
  endtask
  task automatic bus(input logic [7:0] b, input logic cmd, input logic last);
    logic ok;
    u_gpib_ctrl_model.send(b, cmd, last, ok);
    hs(ok);
    repeat (3) @(negedge mclk);
  endtask
  task automatic offer(input logic [7:0] b, input logic last);
    int n;
    @(negedge mclk);
    {tx_valid, tx_data, tx_last} = {1'b1, b, last};
    n = 0;
    while (tx_ready !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    tx_valid = 1'b0;
    hs(n < 1000);
  endtask
  task automatic t_listen;
    primary_addr = 5'h0A;
    bus(8'h2A, 1'b1, 1'b0);
    chk8("command", 8'h2A, last_cmd);
    chk1("listener", 1'b1, listener);
    bus(8'h46, 1'b0, 1'b1);
    chk8("data", 8'h46, last_rx);
    chk1("data end", 1'b1, last_end);
    bus(8'h3F, 1'b1, 1'b0);
    chk1("listener", 1'b0, listener);
  endtask
  task automatic t_secondary;
    bus(8'h6A, 1'b1, 1'b0);
    chk1("listener", 1'b0, listener);
    chk1("talker", 1'b0, talker);
    primary_addr = 5'h1F;
    bus(8'h2A, 1'b1, 1'b0);
    chk1("listener", 1'b1, listener);
    bus(8'h3F, 1'b1, 1'b0);
  endtask
  task automatic t_talk;
    logic [7:0] b0, b1;
    logic e0, e1, k0, k1;
    bus(8'h4A, 1'b1, 1'b0);
    chk1("talker", 1'b1, talker);
    fork
      begin
        offer(8'h31, 1'b0);
        offer(8'h32, 1'b1);
      end
      begin
        u_gpib_ctrl_model.recv(9, b0, e0, k0);
        u_gpib_ctrl_model.recv(0, b1, e1, k1);
      end
    join
    hs(k0 & k1);
    chk8("talk byte", 8'h31, b0);
    chk1("talk end", 1'b0, e0);
    chk8("talk byte", 8'h32, b1);
    chk1("talk end", 1'b1, e1);
    bus(8'h5F, 1'b1, 1'b0);
    chk1("talker", 1'b0, talker);
    chk8("dio oe", 8'hFF, dio_n_oe_n);
  endtask
  task automatic t_mgmt;
    bus(8'h2A, 1'b1, 1'b0);
    bus(8'h4A, 1'b1, 1'b0);
    u_gpib_ctrl_model.uni(1'b1, 1'b0);
    repeat (3) @(negedge mclk);
    chk1("listener", 1'b0, listener);
    chk1("talker", 1'b0, talker);
    u_gpib_ctrl_model.uni(1'b0, 1'b1);
    repeat (3) @(negedge mclk);
    chk1("remote", 1'b1, remote);
    u_gpib_ctrl_model.uni(1'b0, 1'b0);
    service_req = 1'b1;
    repeat (3) @(negedge mclk);
    chk1("remote", 1'b0, remote);
    chk1("srq", 1'b0, srq);
    service_req = 1'b0;
    repeat (3) @(negedge mclk);
    chk1("srq", 1'b1, srq);
  endtask
  initial begin
    {rst, ce, rx_ready, tx_valid, tx_last, service_req} = 6'h38;
    primary_addr = 5'h00;
    tx_data = 8'h00;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    chk1("talker", 1'b0, talker);
    chk8("dio oe", 8'hFF, dio_n_oe_n);
    t_listen;
    t_secondary;
    t_talk;
    t_mgmt;
    end_of_test;
  end
endmodule
